// File: shared/hjps_consts.svh
// Constants for the shared host / boundary-scan control port.
// Assumes the shared clock pin clocks both the host serial engine and the test access port.
//
// Summary of operation
// - Select input low: shared select pin is host chip select, active low.
// - Select input high: shared select pin is test mode select, active high.
// - Host mode: serial output pin returns register contents read from the device.
// - Test mode: serial output pin is the test data output.
// - Host shifts address and data in on serial input; device performs register writes.
// - Test mode: serial input pin is the test data input.
// - Command and data words are captured on the host burst clock.
// - Test mode: shared clock pin is the test clock.
// - Select input steers all four shared pins: high test, low host.
// - Device reset low holds the test sequence in reset until released.
`ifndef HJPS_CONSTS_SVH
`define HJPS_CONSTS_SVH

`define HJPS_CMD_W 16
`define HJPS_DATA_W 16
`define HJPS_ADDR_W 15
`define HJPS_BIT_CNT_W 4
`define HJPS_BIT_LAST 4'hF
`define HJPS_GAP_CNT_W 3
`define HJPS_RD_GAP_LAST 3'h3
`define HJPS_IR_W 4
`define HJPS_IR_CAPTURE 4'h1
`define HJPS_IR_IDCODE 4'h1
`define HJPS_IR_BYPASS 4'hF
`define HJPS_DR_W 32
`define HJPS_IDCODE_DEFAULT 32'h0000_0001

`endif

// File: shared/hjps_pkg.sv
// Types for the shared host / boundary-scan control port.
// Assumes hjps_consts.svh is on the include path.
`include "hjps_consts.svh"

package hjps_pkg;

	// Command word, most significant bit first on the wire
	typedef struct packed {
		logic rd;
		logic [`HJPS_ADDR_W-1:0] addr;
	} hjps_cmd_t;

	// Register write carried to the device core
	typedef struct packed {
		logic [`HJPS_ADDR_W-1:0] addr;
		logic [`HJPS_DATA_W-1:0] data;
	} hjps_wr_t;

	typedef enum logic [2:0] {
		HJPS_H_CMD,
		HJPS_H_GAP,
		HJPS_H_WDATA,
		HJPS_H_RDATA,
		HJPS_H_DONE
	} hjps_host_state_t;

	typedef enum logic [3:0] {
		HJPS_T_RESET, HJPS_T_IDLE,
		HJPS_T_SEL_DR, HJPS_T_CAP_DR, HJPS_T_SH_DR, HJPS_T_EX1_DR,
		HJPS_T_PAU_DR, HJPS_T_EX2_DR, HJPS_T_UPD_DR,
		HJPS_T_SEL_IR, HJPS_T_CAP_IR, HJPS_T_SH_IR, HJPS_T_EX1_IR,
		HJPS_T_PAU_IR, HJPS_T_EX2_IR, HJPS_T_UPD_IR
	} hjps_tap_state_t;

endpackage

// File: hdl/hjps_sync.sv
// Two-flop level synchroniser.
// Assumes the input is a level or toggle that stays put for at least two destination clocks.
module hjps_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta <= '0;
			q_out <= '0;
		end else begin
			meta <= d_in;
			q_out <= meta;
		end
	end

endmodule

// File: hdl/hjps_top.sv
// Shared control port: host serial register interface or boundary-scan access.
// Assumes the link clock is the shared clock pin and only runs during transfers.
`include "hjps_consts.svh"
module hjps_top
	import hjps_pkg::*;
#(
	parameter logic [`HJPS_DR_W-1:0] IDCODE_VALUE = `HJPS_IDCODE_DEFAULT // Arbitrary value
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic link_clk_in,
	input wire logic iface_sel_in,
	input wire logic shared_select_pin_in,
	input wire logic shared_serial_in_pin_in,
	output logic shared_serial_out_pin_out,
	output logic shared_serial_out_oe_out,
	output logic test_mode_out,
	output hjps_wr_t reg_wr_out,
	output logic reg_wr_stb_out,
	output logic [`HJPS_ADDR_W-1:0] reg_rd_addr_out,
	output logic reg_rd_stb_out,
	input wire logic [`HJPS_DATA_W-1:0] reg_rd_data_in
);

	// ----------------------------------------------------------------
	// Link domain: mode and resets
	// ----------------------------------------------------------------
	logic mode_link;
	logic ack_link;
	logic rd_ack_tgl;
	logic host_rst_n;
	logic out_rst_n;

	hjps_sync #(.WIDTH(1)) u_mode_link (
		.clk_in(link_clk_in),
		.rst_n_in(rst_n_in),
		.d_in(iface_sel_in),
		.q_out(mode_link)
	);

	hjps_sync #(.WIDTH(1)) u_ack_link (
		.clk_in(link_clk_in),
		.rst_n_in(rst_n_in),
		.d_in(rd_ack_tgl),
		.q_out(ack_link)
	);

	// Frame ends when chip select rises, clock may stop after it
	assign host_rst_n = rst_n_in & ~shared_select_pin_in;
	assign out_rst_n = rst_n_in & (mode_link | ~shared_select_pin_in);

	// ----------------------------------------------------------------
	// Host serial engine
	// ----------------------------------------------------------------
	hjps_host_state_t state, next_state;
	logic [`HJPS_BIT_CNT_W-1:0] bit_cnt, next_bit_cnt;
	logic [`HJPS_CMD_W-1:0] shreg, next_shreg;
	logic [`HJPS_GAP_CNT_W-1:0] gap_cnt, next_gap_cnt;
	logic [`HJPS_DATA_W-1:0] rd_shreg, next_rd_shreg;
	logic wr_tgl, next_wr_tgl;
	logic rd_tgl, next_rd_tgl;
	hjps_wr_t wr_word, next_wr_word;
	logic [`HJPS_ADDR_W-1:0] rd_addr, next_rd_addr;
	logic [`HJPS_DATA_W-1:0] rd_hold;
	hjps_cmd_t cmd_now;
	logic [`HJPS_CMD_W-1:0] shreg_in;

	always_comb begin
		shreg_in = {shreg[`HJPS_CMD_W-2:0], shared_serial_in_pin_in};
		cmd_now = hjps_cmd_t'(shreg_in);
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_gap_cnt = gap_cnt;
		next_rd_shreg = rd_shreg;
		next_wr_tgl = wr_tgl;
		next_rd_tgl = rd_tgl;
		next_wr_word = wr_word;
		next_rd_addr = rd_addr;
		unique case (state)
			HJPS_H_CMD: begin
				if (!mode_link) begin
					next_shreg = shreg_in;
					next_bit_cnt = bit_cnt + 4'h1;
					if (bit_cnt == `HJPS_BIT_LAST) begin
						next_bit_cnt = '0;
						if (cmd_now.rd) begin
							next_rd_addr = cmd_now.addr;
							next_rd_tgl = ~rd_tgl;
							next_gap_cnt = '0;
							next_state = HJPS_H_GAP;
						end else begin
							next_wr_word.addr = cmd_now.addr;
							next_state = HJPS_H_WDATA;
						end
					end
				end
			end
			HJPS_H_GAP: begin
				next_gap_cnt = gap_cnt + 3'h1;
				if (gap_cnt == `HJPS_RD_GAP_LAST) begin
					// Read word only taken once the core has answered
					next_rd_shreg = (ack_link == rd_tgl) ? rd_hold : '0;
					next_state = HJPS_H_RDATA;
				end
			end
			HJPS_H_WDATA: begin
				next_shreg = shreg_in;
				next_bit_cnt = bit_cnt + 4'h1;
				if (bit_cnt == `HJPS_BIT_LAST) begin
					next_wr_word.data = shreg_in;
					next_wr_tgl = ~wr_tgl;
					next_state = HJPS_H_DONE;
				end
			end
			HJPS_H_RDATA: begin
				next_rd_shreg = {rd_shreg[`HJPS_DATA_W-2:0], 1'b0};
				next_bit_cnt = bit_cnt + 4'h1;
				if (bit_cnt == `HJPS_BIT_LAST) begin
					next_state = HJPS_H_DONE;
				end
			end
			HJPS_H_DONE: begin
				next_state = state;
			end
		endcase
	end

	always_ff @(posedge link_clk_in or negedge host_rst_n) begin
		if (!host_rst_n) begin
			state <= HJPS_H_CMD;
			bit_cnt <= '0;
			shreg <= '0;
			gap_cnt <= '0;
			rd_shreg <= '0;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			gap_cnt <= next_gap_cnt;
			rd_shreg <= next_rd_shreg;
		end
	end

	// Toggles survive frame end so no false event is seen
	always_ff @(posedge link_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_tgl <= 1'b0;
			rd_tgl <= 1'b0;
			wr_word <= '0;
			rd_addr <= '0;
		end else begin
			wr_tgl <= next_wr_tgl;
			rd_tgl <= next_rd_tgl;
			wr_word <= next_wr_word;
			rd_addr <= next_rd_addr;
		end
	end

	// ----------------------------------------------------------------
	// Test access port
	// ----------------------------------------------------------------
	hjps_tap_state_t tap, next_tap;
	logic [`HJPS_IR_W-1:0] ir, next_ir;
	logic [`HJPS_IR_W-1:0] ir_sh, next_ir_sh;
	logic [`HJPS_DR_W-1:0] dr_sh, next_dr_sh;
	logic byp, next_byp;
	logic tms;
	logic tdi;

	assign tms = shared_select_pin_in;
	assign tdi = shared_serial_in_pin_in;

	always_comb begin
		next_tap = tap;
		unique case (tap)
			HJPS_T_RESET: next_tap = tms ? HJPS_T_RESET : HJPS_T_IDLE;
			HJPS_T_IDLE: next_tap = tms ? HJPS_T_SEL_DR : HJPS_T_IDLE;
			HJPS_T_SEL_DR: next_tap = tms ? HJPS_T_SEL_IR : HJPS_T_CAP_DR;
			HJPS_T_CAP_DR: next_tap = tms ? HJPS_T_EX1_DR : HJPS_T_SH_DR;
			HJPS_T_SH_DR: next_tap = tms ? HJPS_T_EX1_DR : HJPS_T_SH_DR;
			HJPS_T_EX1_DR: next_tap = tms ? HJPS_T_UPD_DR : HJPS_T_PAU_DR;
			HJPS_T_PAU_DR: next_tap = tms ? HJPS_T_EX2_DR : HJPS_T_PAU_DR;
			HJPS_T_EX2_DR: next_tap = tms ? HJPS_T_UPD_DR : HJPS_T_SH_DR;
			HJPS_T_UPD_DR: next_tap = tms ? HJPS_T_SEL_DR : HJPS_T_IDLE;
			HJPS_T_SEL_IR: next_tap = tms ? HJPS_T_RESET : HJPS_T_CAP_IR;
			HJPS_T_CAP_IR: next_tap = tms ? HJPS_T_EX1_IR : HJPS_T_SH_IR;
			HJPS_T_SH_IR: next_tap = tms ? HJPS_T_EX1_IR : HJPS_T_SH_IR;
			HJPS_T_EX1_IR: next_tap = tms ? HJPS_T_UPD_IR : HJPS_T_PAU_IR;
			HJPS_T_PAU_IR: next_tap = tms ? HJPS_T_EX2_IR : HJPS_T_PAU_IR;
			HJPS_T_EX2_IR: next_tap = tms ? HJPS_T_UPD_IR : HJPS_T_SH_IR;
			HJPS_T_UPD_IR: next_tap = tms ? HJPS_T_SEL_DR : HJPS_T_IDLE;
		endcase
		// Host mode parks the port in its reset state
		if (!mode_link) begin
			next_tap = HJPS_T_RESET;
		end
	end

	always_comb begin
		next_ir = ir;
		next_ir_sh = ir_sh;
		next_dr_sh = dr_sh;
		next_byp = byp;
		unique case (tap)
			HJPS_T_RESET: next_ir = `HJPS_IR_IDCODE;
			HJPS_T_CAP_IR: next_ir_sh = `HJPS_IR_CAPTURE;
			HJPS_T_SH_IR: next_ir_sh = {tdi, ir_sh[`HJPS_IR_W-1:1]};
			HJPS_T_UPD_IR: next_ir = ir_sh;
			HJPS_T_CAP_DR: begin
				next_dr_sh = (ir == `HJPS_IR_IDCODE) ? IDCODE_VALUE : '0;
				next_byp = 1'b0;
			end
			HJPS_T_SH_DR: begin
				next_dr_sh = {tdi, dr_sh[`HJPS_DR_W-1:1]};
				next_byp = tdi;
			end
			default: next_ir = ir;
		endcase
	end

	// Clocked by the shared clock pin as test clock
	always_ff @(posedge link_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tap <= HJPS_T_RESET;
			ir <= `HJPS_IR_IDCODE;
			ir_sh <= '0;
			dr_sh <= '0;
			byp <= 1'b0;
		end else begin
			tap <= next_tap;
			ir <= next_ir;
			ir_sh <= next_ir_sh;
			dr_sh <= next_dr_sh;
			byp <= next_byp;
		end
	end

	// ----------------------------------------------------------------
	// Shared serial output, updated on falling link edge
	// ----------------------------------------------------------------
	logic next_sout;
	logic next_soe;

	always_comb begin
		next_sout = 1'b0;
		next_soe = 1'b0;
		if (mode_link) begin
			if (tap == HJPS_T_SH_IR) begin
				next_sout = ir_sh[0];
				next_soe = 1'b1;
			end else if (tap == HJPS_T_SH_DR) begin
				next_sout = (ir == `HJPS_IR_IDCODE) ? dr_sh[0] : byp;
				next_soe = 1'b1;
			end
		end else if (state == HJPS_H_RDATA) begin
			next_sout = rd_shreg[`HJPS_DATA_W-1];
			next_soe = 1'b1;
		end
	end

	always_ff @(negedge link_clk_in or negedge out_rst_n) begin
		if (!out_rst_n) begin
			shared_serial_out_pin_out <= 1'b0;
			shared_serial_out_oe_out <= 1'b0;
		end else begin
			shared_serial_out_pin_out <= next_sout;
			shared_serial_out_oe_out <= next_soe;
		end
	end

	// ----------------------------------------------------------------
	// System domain: register requests toward the core
	// ----------------------------------------------------------------
	logic wr_sync;
	logic rd_sync;
	logic wr_seen, next_wr_seen;
	logic rd_seen, next_rd_seen;
	logic rd_pend, next_rd_pend;
	logic next_wr_stb;
	logic next_rd_stb;
	hjps_wr_t next_wr_out;
	logic [`HJPS_ADDR_W-1:0] next_rd_addr_out;
	logic [`HJPS_DATA_W-1:0] next_rd_hold;
	logic next_ack_tgl;

	hjps_sync #(.WIDTH(1)) u_mode_sys (
		.clk_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.d_in(iface_sel_in),
		.q_out(test_mode_out)
	);

	hjps_sync #(.WIDTH(2)) u_req_sys (
		.clk_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.d_in({wr_tgl, rd_tgl}),
		.q_out({wr_sync, rd_sync})
	);

	always_comb begin
		next_wr_seen = wr_sync;
		next_rd_seen = rd_sync;
		next_wr_stb = wr_sync ^ wr_seen;
		next_rd_stb = rd_sync ^ rd_seen;
		next_wr_out = next_wr_stb ? wr_word : reg_wr_out;
		next_rd_addr_out = next_rd_stb ? rd_addr : reg_rd_addr_out;
		next_rd_pend = reg_rd_stb_out;
		next_rd_hold = rd_pend ? reg_rd_data_in : rd_hold;
		next_ack_tgl = rd_pend ? ~rd_ack_tgl : rd_ack_tgl;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_seen <= 1'b0;
			rd_seen <= 1'b0;
			reg_wr_stb_out <= 1'b0;
			reg_rd_stb_out <= 1'b0;
			reg_wr_out <= '0;
			reg_rd_addr_out <= '0;
			rd_pend <= 1'b0;
			rd_hold <= '0;
			rd_ack_tgl <= 1'b0;
		end else begin
			wr_seen <= next_wr_seen;
			rd_seen <= next_rd_seen;
			reg_wr_stb_out <= next_wr_stb;
			reg_rd_stb_out <= next_rd_stb;
			reg_wr_out <= next_wr_out;
			reg_rd_addr_out <= next_rd_addr_out;
			rd_pend <= next_rd_pend;
			rd_hold <= next_rd_hold;
			rd_ack_tgl <= next_ack_tgl;
		end
	end

endmodule

// File: testbench/hjps_checker.sv
// Concurrent checks on the ports of hjps_top.
// Assumes it is bound to hjps_top from the bench.
module hjps_checker
	import hjps_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic link_clk_in,
	input wire logic iface_sel_in,
	input wire logic shared_select_pin_in,
	input wire logic shared_serial_out_oe_out,
	input wire logic test_mode_out,
	input wire hjps_wr_t reg_wr_out,
	input wire logic reg_wr_stb_out,
	input wire logic reg_rd_stb_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	logic [1:0] since_rst;
	logic [1:0] next_since_rst;
	logic [5:0] oe_run;
	logic [5:0] next_oe_run;

	always_comb begin
		next_since_rst = (since_rst == 2'h3) ? since_rst : since_rst + 2'h1;
		next_oe_run = shared_serial_out_oe_out ? oe_run + 6'h01 : 6'h00;
	end
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in)
			since_rst <= 2'h0;
		else
			since_rst <= next_since_rst;
	end
	always_ff @(negedge link_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			oe_run <= 6'h00;
		else
			oe_run <= next_oe_run;
	end

	a_wr_pulse: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		reg_wr_stb_out |=> !reg_wr_stb_out) else $error("write strobe too long");
	a_rd_pulse: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		reg_rd_stb_out |=> !reg_rd_stb_out && !reg_wr_stb_out) else $error("read strobe bad");
	a_wr_held: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!reg_wr_stb_out |-> $stable(reg_wr_out)) else $error("write word moved");
	a_mode_follow: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		since_rst == 2'h3 && iface_sel_in == $past(iface_sel_in)
		&& iface_sel_in == $past(iface_sel_in, 2) |-> test_mode_out == iface_sel_in)
		else $error("mode flag wrong");
	a_test_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		test_mode_out |-> !reg_wr_stb_out && !reg_rd_stb_out) else $error("strobe in test mode");
	a_reset_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(rst_n_in) |-> !test_mode_out && !reg_wr_stb_out && reg_wr_out == '0)
		else $error("outputs not cleared by reset");
	a_cs_idle: assert property (@(negedge link_clk_in) disable iff (!rst_n_in)
		!iface_sel_in && shared_select_pin_in |-> !shared_serial_out_oe_out)
		else $error("output driven without chip select");
	a_oe_len: assert property (@(negedge link_clk_in) disable iff (!rst_n_in)
		!iface_sel_in && $fell(shared_serial_out_oe_out) |-> oe_run == 6'h10)
		else $error("read data length wrong");
endmodule

// File: testbench/hjps_link_host.sv
// Host controller and boundary-scan tester on the shared pins.
// Assumes the bench calls frame with select and data patterns, first bit highest.
module hjps_link_host (
	input wire logic serial_out_in,
	output logic link_clk_out,
	output logic select_out,
	output logic serial_in_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Frame driver, 80 ns link clock
	// ----------------------------------------
	initial begin
		link_clk_out = 1'b0;
		select_out = 1'b1; // Idle high
		serial_in_out = 1'b1;
	end
	task automatic frame(input int n, input logic [63:0] sel, input logic [63:0] din,
		output logic [63:0] dout);
		dout = '0;
		// Idle gap so back-to-back frames never touch a pin twice in one step
		#40;
		for (int i = n - 1; i >= 0; i--) begin
			select_out = sel[i];
			serial_in_out = din[i];
			#40;
			dout = {dout[62:0], serial_out_in};
			link_clk_out = 1'b1; // Clock for the whole transfer
			#40;
			link_clk_out = 1'b0;
		end
		select_out = 1'b1;
		serial_in_out = ~serial_in_out;
	endtask
endmodule

// File: testbench/hjps_top_bench.sv
// Self-checking bench for the shared host / boundary-scan port.
// Assumes the package, checker and link host model are compiled first.
`include "hjps_consts.svh"
module hjps_top_bench
	import hjps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] ID_VAL = 32'h5A3C_0F01; // Arbitrary value
	logic clk_sys = 1'b1;
	logic rst_n = 1'b1;
	logic rd_stb_q = 1'b0;
	logic iface_sel = 1'b0;
	logic [15:0] rd_data = 16'h0000;
	logic link_clk, sel_pin, sdi, sdo, sdo_oe, test_mode, wr_stb, rd_stb;
	hjps_wr_t wr_word, wr_seen;
	logic [`HJPS_ADDR_W-1:0] rd_addr, rd_seen;
	logic [63:0] q;
	int fails = 0;
	int comparisons = 0;
	int wr_cnt = 0;
	int rd_cnt = 0;
	wire pin_level = sdo_oe ? sdo : 1'bz;

	hjps_top #(.IDCODE_VALUE(ID_VAL)) u_hjps_top (.clk_sys_in(clk_sys), .rst_n_in(rst_n),
		.link_clk_in(link_clk), .iface_sel_in(iface_sel), .shared_select_pin_in(sel_pin),
		.shared_serial_in_pin_in(sdi), .shared_serial_out_pin_out(sdo),
		.shared_serial_out_oe_out(sdo_oe), .test_mode_out(test_mode), .reg_wr_out(wr_word),
		.reg_wr_stb_out(wr_stb), .reg_rd_addr_out(rd_addr), .reg_rd_stb_out(rd_stb),
		.reg_rd_data_in(rd_data));
	hjps_link_host u_hjps_link_host (.serial_out_in(pin_level), .link_clk_out(link_clk),
		.select_out(sel_pin), .serial_in_out(sdi));

	initial forever #4 clk_sys = ~clk_sys;
	function automatic logic [15:0] rdval(input logic [`HJPS_ADDR_W-1:0] a);
		return {1'b1, a} ^ 16'hC3A5;
	endfunction
	always @(posedge clk_sys) begin
		if (wr_stb) begin
			wr_cnt++;
			wr_seen = wr_word;
		end
		if (rd_stb) begin
			rd_cnt++;
			rd_seen = rd_addr;
		end
	end
	// Core holds read data through the cycle after the strobe
	always @(negedge clk_sys) begin
		rd_stb_q <= rd_stb;
		rd_data <= (rd_stb || rd_stb_q) ? rdval(rd_addr) : ~rd_data;
	end

	// ----------------------------------------
	// Checking and scenarios
	// ----------------------------------------
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic host_write(input logic [14:0] a, input logic [15:0] d);
		int was;
		was = wr_cnt;
		u_hjps_link_host.frame(34, 64'h3_0000_0000, {32'h0, 1'b0, a, d}, q);
		repeat (6) @(negedge clk_sys);
		check("write count", wr_cnt, was + 1);
		check("write word", wr_seen, {a, d});
	endtask
	task automatic host_read(input logic [14:0] a);
		int was;
		was = rd_cnt;
		u_hjps_link_host.frame(38, 64'h30_0000_0000, {28'h0, 1'b1, a, 20'h0}, q);
		check("read count", rd_cnt, was + 1);
		check("read address", rd_seen, a);
		check("read data", q[15:0], rdval(a));
	endtask
	task automatic t_cs_high();
		int was;
		was = wr_cnt + rd_cnt;
		u_hjps_link_host.frame(34, 64'h3_FFFF_FFFF, {32'h0, 1'b0, 15'h1234, 16'hBEEF}, q);
		repeat (6) @(negedge clk_sys);
		check("no transfer", wr_cnt + rd_cnt, was);
	endtask
	task automatic t_mode(input logic v);
		@(negedge clk_sys);
		iface_sel = v; // Only between transfers
		for (int i = 0; i < 10 && test_mode !== v; i++) @(negedge clk_sys);
		check("mode flag", test_mode, v);
		if (test_mode !== v)
			give_verdict();
	endtask
	task automatic t_bypass();
		int was;
		was = wr_cnt;
		u_hjps_link_host.frame(29, 64'h1F60_D006, (64'hF << 15) | (64'hB4 << 2), q);
		check("ir capture", q[18:15], 4'h8);
		check("bypass data", q[9:2], 8'h5A);
		check("no write in test", wr_cnt, was);
	endtask
	task automatic t_reset_id();
		logic [31:0] id;
		@(negedge clk_sys);
		rst_n = 1'b0;
		repeat (3) @(negedge clk_sys);
		rst_n = 1'b1;
		t_mode(1'b1);
		u_hjps_link_host.frame(40, 64'h10_0000_0006, 64'h0, q);
		id = {<<{q[33:2]}};
		check("id after reset", id, ID_VAL);
	endtask

	initial begin
		// Real falling reset edge so the link-side flops clear too
		@(negedge clk_sys);
		rst_n = 1'b0;
		repeat (20) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		check("mode after reset", test_mode, 1'b0);
		host_write(15'h0000, 16'hFFFF);
		host_write(15'h7FFF, 16'h0001);
		host_read(15'h2A5B);
		t_cs_high();
		t_mode(1'b1);
		t_bypass();
		t_reset_id();
		t_mode(1'b0);
		host_write(15'h5555, 16'hA5A5);
		give_verdict();
	end
endmodule

bind hjps_top hjps_checker u_hjps_checker (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
	.link_clk_in(link_clk_in), .iface_sel_in(iface_sel_in),
	.shared_select_pin_in(shared_select_pin_in),
	.shared_serial_out_oe_out(shared_serial_out_oe_out), .test_mode_out(test_mode_out),
	.reg_wr_out(reg_wr_out), .reg_wr_stb_out(reg_wr_stb_out), .reg_rd_stb_out(reg_rd_stb_out));
